/* verilog/mstop_ctrl.sv */
// Module stop control: stop register and registered per-module stop indications
//
// Function
// - Set bit halts module after bus cycle
// - Cleared bit resumes module after bus cycle
// - Serial channels and converter lose state
// - After reset only memory access and transfer controllers run
// - Stopped module register access disabled
// - Upper byte bits 15..9 map modules
// - Lower byte bits 7..5 map serial channels
// - Bits 8, 4..0 are plain storage
// - Stopped module does no interrupts
`timescale 1ns/1ps
`default_nettype none

module mstop_ctrl
  import mstop_pkg::*;
(
  input  wire logic                    SYS_CLK,
  input  wire logic                    RESETN,
  input  wire logic [MSTOP_ADDR_W-1:0] ADDR,
  input  wire logic [7:0]              WDATA,
  input  wire logic                    WR,
  input  wire logic                    RD,
  input  wire logic                    BUS_CYCLE_END,
  input  wire logic                    MAC_ACTIVE,
  input  wire logic                    XFER_ACTIVE,
  output var  logic [7:0]              RDATA,
  output var  mstop_halt_t             HALT,
  output var  logic                    SC2_CLEAR,
  output var  logic                    SC1_CLEAR,
  output var  logic                    SC0_CLEAR,
  output var  logic                    ADC_CLEAR,
  output var  logic [9:0]              ACCESS_BLOCK
);

  // Scope, for whoever wires this in:
  // - it only raises stop, clear and access-block levels; each module gates its own
  //   clock and register decode from them, so a stopped module raises no interrupts
  // - a request left pending in a module that is then stopped can be neither cleared
  //   nor serviced until it runs again; software turns such interrupts off first
  // - stopping every module and then sleeping also halts the bus controller; nothing
  //   here guards against it, that is the software's duty
  // - the register port is taken to belong to the CPU alone; other bus masters are not
  //   told apart, so that duty rests on the system wiring

  logic [15:0]  stop_reg;
  logic [15:0]  next_stop_reg;
  logic [7:0]   next_rdata;
  mstop_halt_t  halt_want;
  mstop_halt_t  next_halt;
  logic         next_sc2_clear;
  logic         next_sc1_clear;
  logic         next_sc0_clear;
  logic         next_adc_clear;

  // Reset picture of the stop indications, built bit by bit from the register
  // reset value so the two can never drift apart
  localparam mstop_halt_t halt_reset = '{
    mac:  MSTOP_RESET[MSTOP_BIT_MAC],
    xfer: MSTOP_RESET[MSTOP_BIT_XFER],
    ptu:  MSTOP_RESET[MSTOP_BIT_PTU],
    tmr8: MSTOP_RESET[MSTOP_BIT_TMR8],
    pulse_pattern_generator:  MSTOP_RESET[MSTOP_BIT_PPG],
    dac:  MSTOP_RESET[MSTOP_BIT_DAC],
    adc:  MSTOP_RESET[MSTOP_BIT_ADC],
    sc2:  MSTOP_RESET[MSTOP_BIT_SC2],
    sc1:  MSTOP_RESET[MSTOP_BIT_SC1],
    sc0:  MSTOP_RESET[MSTOP_BIT_SC0]
  };

  // Masks ORed from one-hot terms: every bit that steers a module, and the two controllers that run
  // out of reset
  localparam logic [15:0] live_bits = (16'h0001 << MSTOP_BIT_MAC)  |
                                      (16'h0001 << MSTOP_BIT_XFER) |
                                      (16'h0001 << MSTOP_BIT_PTU)  |
                                      (16'h0001 << MSTOP_BIT_TMR8) |
                                      (16'h0001 << MSTOP_BIT_PPG)  |
                                      (16'h0001 << MSTOP_BIT_DAC)  |
                                      (16'h0001 << MSTOP_BIT_ADC)  |
                                      (16'h0001 << MSTOP_BIT_SC2)  |
                                      (16'h0001 << MSTOP_BIT_SC1)  |
                                      (16'h0001 << MSTOP_BIT_SC0);
  localparam logic [15:0] run_bits  = (16'h0001 << MSTOP_BIT_MAC) |
                                      (16'h0001 << MSTOP_BIT_XFER);

  // Layout checks at elaboration: a clash would let one bit steer two modules, or
  // leave a module running out of reset that should be stopped
  if (MSTOP_OFS_HIGH == MSTOP_OFS_LOW) begin : g_bad_map
    $error("high and low stop registers share one index");
  end
  if (live_bits != MSTOP_LIVE_MASK) begin : g_bad_mask
    $error("module stop bits overlap or disagree with the live mask");
  end
  if (MSTOP_BIT_SC2 >= MSTOP_BIT_ADC) begin : g_bad_order
    $error("serial channel stop bits must sit below the converter bit");
  end
  if ((MSTOP_RESET & live_bits) != (live_bits & ~run_bits)) begin : g_bad_reset
    $error("reset value must stop every module but the two controllers");
  end

  // Register writes; controller stop bits cannot be set while busy
  always_comb begin
    next_stop_reg = stop_reg;
    if (WR && ADDR == MSTOP_OFS_HIGH) begin
      next_stop_reg[15:8] = WDATA;
      if (MAC_ACTIVE && !stop_reg[MSTOP_BIT_MAC]) begin
        next_stop_reg[MSTOP_BIT_MAC] = 1'b0;
      end
      if (XFER_ACTIVE && !stop_reg[MSTOP_BIT_XFER]) begin
        next_stop_reg[MSTOP_BIT_XFER] = 1'b0;
      end
    end else if (WR && ADDR == MSTOP_OFS_LOW) begin
      next_stop_reg[7:0] = WDATA;
    end
  end

  // Read data valid only the cycle after the read strobe
  always_comb begin
    next_rdata = MSTOP_ZERO8;
    if (RD) begin
      next_rdata = (ADDR == MSTOP_OFS_HIGH) ? stop_reg[15:8] : stop_reg[7:0];
    end
  end

  // Map register bits onto module stop requests
  always_comb begin
    halt_want.mac  = stop_reg[MSTOP_BIT_MAC];
    halt_want.xfer = stop_reg[MSTOP_BIT_XFER];
    halt_want.ptu  = stop_reg[MSTOP_BIT_PTU];
    halt_want.tmr8 = stop_reg[MSTOP_BIT_TMR8];
    halt_want.pulse_pattern_generator  = stop_reg[MSTOP_BIT_PPG];
    halt_want.dac  = stop_reg[MSTOP_BIT_DAC];
    halt_want.adc  = stop_reg[MSTOP_BIT_ADC];
    halt_want.sc2  = stop_reg[MSTOP_BIT_SC2];
    halt_want.sc1  = stop_reg[MSTOP_BIT_SC1];
    halt_want.sc0  = stop_reg[MSTOP_BIT_SC0];
  end

  // Stop indications move only when the current bus cycle ends,
  // so a module never sees its stop change mid-access
  always_comb begin
    next_halt = HALT;
    if (BUS_CYCLE_END) begin
      next_halt = halt_want;
    end
    // Modules without retention are held in clear while stopped
    next_sc2_clear = next_halt.sc2;
    next_sc1_clear = next_halt.sc1;
    next_sc0_clear = next_halt.sc0;
    next_adc_clear = next_halt.adc;
  end

  // All state registers
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      stop_reg     <= MSTOP_RESET;
      RDATA        <= MSTOP_ZERO8;
      HALT         <= halt_reset;
      // Serial channels and converter start out cleared; modules stopped at reset start out shut off from access
      SC2_CLEAR    <= halt_reset.sc2;
      SC1_CLEAR    <= halt_reset.sc1;
      SC0_CLEAR    <= halt_reset.sc0;
      ADC_CLEAR    <= halt_reset.adc;
      ACCESS_BLOCK <= halt_reset;
    end else begin
      stop_reg     <= next_stop_reg;
      RDATA        <= next_rdata;
      HALT         <= next_halt;
      SC2_CLEAR    <= next_sc2_clear;
      SC1_CLEAR    <= next_sc1_clear;
      SC0_CLEAR    <= next_sc0_clear;
      ADC_CLEAR    <= next_adc_clear;
      ACCESS_BLOCK <= next_halt;
    end
  end

  // Assertions: each sits beside the rule it guards; all but the reset check are
  // switched off while reset is held, since the outputs then sit at their reset
  // picture rather than at what the register asks for

  // Reset picture seen on the first edge after release
  property p_reset_value;
    @(posedge SYS_CLK)
      $rose(RESETN) |-> stop_reg == MSTOP_RESET && HALT == halt_reset;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("stop register reset value wrong");

  // Outside a boundary the indications hold still
  property p_halt_hold;
    @(posedge SYS_CLK) disable iff (!RESETN)
      !BUS_CYCLE_END |=> $stable(HALT);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt moved mid cycle");

  // A set bit stops its module at the next boundary
  property p_halt_set;
    @(posedge SYS_CLK) disable iff (!RESETN)
      BUS_CYCLE_END && stop_reg[MSTOP_BIT_PTU] |=> HALT.ptu;
  endproperty
  a_halt_set: assert property (p_halt_set) else $error("module not halted");

  // A cleared bit lets its module run and out of its clear
  property p_halt_clr;
    @(posedge SYS_CLK) disable iff (!RESETN)
      BUS_CYCLE_END && !stop_reg[MSTOP_BIT_SC0] |=> !HALT.sc0 && !SC0_CLEAR;
  endproperty
  a_halt_clr: assert property (p_halt_clr) else $error("module not resumed");

  // A stopped serial channel is held cleared
  property p_clear_sc;
    @(posedge SYS_CLK) disable iff (!RESETN)
      HALT.sc1 |-> SC1_CLEAR;
  endproperty
  a_clear_sc: assert property (p_clear_sc) else $error("serial state kept");

  // Register access follows the stop indications
  property p_block;
    @(posedge SYS_CLK) disable iff (!RESETN)
      1'b1 |-> ACCESS_BLOCK == HALT;
  endproperty
  a_block: assert property (p_block) else $error("access not blocked");

  // A busy memory access controller keeps running
  property p_refuse;
    @(posedge SYS_CLK) disable iff (!RESETN)
      WR && ADDR == MSTOP_OFS_HIGH && MAC_ACTIVE && !stop_reg[MSTOP_BIT_MAC]
        |=> !stop_reg[MSTOP_BIT_MAC];
  endproperty
  a_refuse: assert property (p_refuse) else $error("busy controller stopped");

  // Spare bits are plain storage
  property p_spare;
    @(posedge SYS_CLK) disable iff (!RESETN)
      WR && ADDR == MSTOP_OFS_LOW |=> stop_reg[4:0] == $past(WDATA[4:0]);
  endproperty
  a_spare: assert property (p_spare) else $error("spare bits not stored");

  // Low byte reads back as stored
  property p_readback;
    @(posedge SYS_CLK) disable iff (!RESETN)
      RD && ADDR == MSTOP_OFS_LOW |=> RDATA == $past(stop_reg[7:0]);
  endproperty
  a_readback: assert property (p_readback) else $error("read data wrong");

  // High byte reads back as stored
  property p_read_high;
    @(posedge SYS_CLK) disable iff (!RESETN)
      RD && ADDR == MSTOP_OFS_HIGH |=> RDATA == $past(stop_reg[15:8]);
  endproperty
  a_read_high: assert property (p_read_high) else $error("high byte read wrong");

  // Read data stand for one cycle only; a stale byte would otherwise be read twice
  property p_rdata_idle;
    @(posedge SYS_CLK) disable iff (!RESETN)
      !RD |=> RDATA == MSTOP_ZERO8;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");

  // Idle controllers take the whole high byte as written
  property p_store_high;
    @(posedge SYS_CLK) disable iff (!RESETN)
      WR && ADDR == MSTOP_OFS_HIGH && !MAC_ACTIVE && !XFER_ACTIVE
        |=> stop_reg[15:8] == $past(WDATA);
  endproperty
  a_store_high: assert property (p_store_high) else $error("high byte not stored");

  // Serial channel bits land with the low byte
  property p_store_low;
    @(posedge SYS_CLK) disable iff (!RESETN)
      WR && ADDR == MSTOP_OFS_LOW |=> stop_reg[7:0] == $past(WDATA);
  endproperty
  a_store_low: assert property (p_store_low) else $error("low byte not stored");

  // A busy transfer controller keeps running as well
  property p_refuse_xfer;
    @(posedge SYS_CLK) disable iff (!RESETN)
      WR && ADDR == MSTOP_OFS_HIGH && XFER_ACTIVE && !stop_reg[MSTOP_BIT_XFER]
        |=> !stop_reg[MSTOP_BIT_XFER];
  endproperty
  a_refuse_xfer: assert property (p_refuse_xfer) else $error("busy controller stopped");

  // At a boundary every indication takes the register picture at once
  property p_halt_follow;
    @(posedge SYS_CLK) disable iff (!RESETN)
      BUS_CYCLE_END |=> HALT == $past(halt_want);
  endproperty
  a_halt_follow: assert property (p_halt_follow) else $error("halt missed boundary");

  // The converter is held cleared exactly while it is stopped
  property p_clear_adc;
    @(posedge SYS_CLK) disable iff (!RESETN)
      ADC_CLEAR == HALT.adc;
  endproperty
  a_clear_adc: assert property (p_clear_adc) else $error("converter clear wrong");

  // A resumed serial channel is let out of its clear
  property p_clear_release;
    @(posedge SYS_CLK) disable iff (!RESETN)
      !HALT.sc2 |-> !SC2_CLEAR;
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("serial clear stuck");

  // Main scenarios
  c_stop: cover property (@(posedge SYS_CLK) disable iff (!RESETN) $rose(HALT.dac));
  c_run: cover property (@(posedge SYS_CLK) disable iff (!RESETN) $fell(HALT.adc));
  c_refuse: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    WR && ADDR == MSTOP_OFS_HIGH && XFER_ACTIVE);
  c_refuse_mac: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    WR && ADDR == MSTOP_OFS_HIGH && MAC_ACTIVE && !stop_reg[MSTOP_BIT_MAC]);
  c_all_run: cover property (@(posedge SYS_CLK) disable iff (!RESETN) HALT == MSTOP_ZERO10);

endmodule : mstop_ctrl

`default_nettype wire

/* verilog/mstop_pkg.sv */
// Package for the module stop control block: register map, bit layout, reset values
package mstop_pkg;

  localparam int unsigned MSTOP_ADDR_W = 1;
  // Register indices (byte-wide registers on the plain register port)
  localparam logic [MSTOP_ADDR_W-1:0] MSTOP_OFS_HIGH = 1'h0;
  localparam logic [MSTOP_ADDR_W-1:0] MSTOP_OFS_LOW  = 1'h1;

  // Stop bit positions within the 16-bit stop register
  localparam int unsigned MSTOP_BIT_MAC  = 15;
  localparam int unsigned MSTOP_BIT_XFER = 14;
  localparam int unsigned MSTOP_BIT_PTU  = 13;
  localparam int unsigned MSTOP_BIT_TMR8 = 12;
  localparam int unsigned MSTOP_BIT_PPG  = 11;
  localparam int unsigned MSTOP_BIT_DAC  = 10;
  localparam int unsigned MSTOP_BIT_ADC  = 9;
  localparam int unsigned MSTOP_BIT_SC2  = 7;
  localparam int unsigned MSTOP_BIT_SC1  = 6;
  localparam int unsigned MSTOP_BIT_SC0  = 5;

  // Reset: everything stopped except memory access and transfer controllers
  localparam logic [15:0] MSTOP_RESET = 16'h3fff;
  // Bits that steer a module
  localparam logic [15:0] MSTOP_LIVE_MASK = 16'hfee0;
  localparam logic [7:0]  MSTOP_ZERO8 = 8'h00;
  localparam logic [9:0]  MSTOP_ZERO10 = 10'h000;

  // Stop indications to the supporting modules
  typedef struct packed {
    logic mac;
    logic xfer;
    logic ptu;
    logic tmr8;
    logic pulse_pattern_generator;
    logic dac;
    logic adc;
    logic sc2;
    logic sc1;
    logic sc0;
  } mstop_halt_t;

endpackage : mstop_pkg

/* verif/mstop_periph_model.sv */
// Far-side model: bus cycle boundaries and controller busy levels
`timescale 1ns/1ps
`default_nettype none
module mstop_periph_model #(
  parameter int CYC = 3
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic mac_req,
  input  wire logic xfer_req,
  output var  logic cyc_end,
  output var  logic mac_act,
  output var  logic xfer_act
);
  int cnt;
  // Long bus cycles so a halt change must wait for its boundary
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      cyc_end <= 1'b0;
      mac_act <= 1'b0;
      xfer_act <= 1'b0;
    end else begin
      cnt <= (cnt == CYC - 1) ? 0 : cnt + 1;
      cyc_end <= (cnt == CYC - 1);
      mac_act <= mac_req;
      xfer_act <= xfer_req;
    end
  end
endmodule : mstop_periph_model
`default_nettype wire

/* verif/mstop_ctrl_tb_top.sv */
// Testbench for the module stop control block
`timescale 1ns/1ps
`default_nettype none
module mstop_ctrl_tb_top;
  import mstop_pkg::*;
  logic [MSTOP_ADDR_W-1:0] addr;
  logic [7:0]              wdata, rdata, v;
  logic                    clk, rst_n, wr, rd, cyc_end, mac_act, xfer_act, mac_req, xfer_req;
  logic                    sc2c, sc1c, sc0c, adcc;
  logic [9:0]              blk;
  logic [15:0]             w;
  mstop_halt_t             halt;
  int                      err_count, checks_done;
  int                      pos[10] = '{15, 14, 13, 12, 11, 10, 9, 7, 6, 5};
  mstop_ctrl dut_u (.SYS_CLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .BUS_CYCLE_END(cyc_end), .MAC_ACTIVE(mac_act), .XFER_ACTIVE(xfer_act),
    .RDATA(rdata), .HALT(halt), .SC2_CLEAR(sc2c), .SC1_CLEAR(sc1c), .SC0_CLEAR(sc0c),
    .ADC_CLEAR(adcc), .ACCESS_BLOCK(blk));
  mstop_periph_model model_u (.clk(clk), .rst_n(rst_n), .mac_req(mac_req),
    .xfer_req(xfer_req), .cyc_end(cyc_end), .mac_act(mac_act), .xfer_act(xfer_act));
  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic end_sim();
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Strobe stays up so back-to-back writes never touch it twice in one step
  task automatic wr_reg(input logic [MSTOP_ADDR_W-1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [MSTOP_ADDR_W-1:0] a, output logic [7:0] d);
    wr <= 1'b0;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg
  // Wait for a sampled bus cycle end, then one edge for the halt register
  task automatic settle();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cyc_end !== 1'b1 && n < 20);
    if (cyc_end !== 1'b1) begin
      err_count++;
      end_sim();
    end else begin
      @(posedge clk);
    end
  endtask : settle
  task automatic put(input logic [7:0] hi, input logic [7:0] lo);
    wr_reg(MSTOP_OFS_HIGH, hi);
    wr_reg(MSTOP_OFS_LOW, lo);
    rd_reg(MSTOP_OFS_HIGH, v);
    chk(16'(v), 16'(hi));
    rd_reg(MSTOP_OFS_LOW, v);
    chk(16'(v), 16'(lo));
    settle();
    chk(16'(halt), 16'({hi[7:1], lo[7:5]}));
    chk(16'(blk), 16'({hi[7:1], lo[7:5]}));
    chk(16'({sc2c, sc1c, sc0c, adcc}), 16'({lo[7:5], hi[1]}));
  endtask : put
  // Main sequence; sleep is never entered, so no halted bus controller
  initial begin
    {addr, wdata, wr, rd, mac_req, xfer_req, err_count, checks_done} = '0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(16'(halt), 16'h00ff);
    chk(16'(blk), 16'h00ff);
    chk(16'({sc2c, sc1c, sc0c, adcc}), 16'h000f);
    rd_reg(MSTOP_OFS_HIGH, v);
    chk(16'(v), 16'h003f);
    rd_reg(MSTOP_OFS_LOW, v);
    chk(16'(v), 16'h00ff);
    for (int i = 0; i < 10; i++) begin
      w = 16'h0001 << pos[i];
      put(w[15:8], w[7:0]);
    end
    put(8'h01, 8'h1f);
    // Busy controllers refuse their stop bits
    mac_req <= 1'b1;
    xfer_req <= 1'b1;
    repeat (2) @(posedge clk);
    wr_reg(MSTOP_OFS_HIGH, 8'hc2);
    rd_reg(MSTOP_OFS_HIGH, v);
    chk(16'(v), 16'h0002);
    mac_req <= 1'b0;
    xfer_req <= 1'b0;
    repeat (2) @(posedge clk);
    put(8'hc0, 8'he0);
    put(8'h00, 8'h00);
    end_sim();
  end
endmodule : mstop_ctrl_tb_top
`default_nettype wire
